// File: src/tws_pkg.sv
// tws_pkg: register map, field positions, reset values and command codes
// of the two-wire slave control and status block.
// assumes an 8-bit register port addressed by register offset.
package tws_pkg;

  // register offsets
  localparam logic [7:0] SLAVE_CONTROL_A_OFS = 8'h09;
  localparam logic [7:0] SLAVE_CONTROL_B_OFS = 8'h0a;
  localparam logic [7:0] SLAVE_STATUS_OFS    = 8'h0b;
  localparam logic [7:0] OWN_ADDRESS_OFS     = 8'h0c;
  localparam logic [7:0] SHIFT_DATA_OFS      = 8'h0d;

  // reset values
  localparam logic [7:0] SLAVE_CONTROL_A_RST = 8'h00;
  localparam logic [7:0] OWN_ADDRESS_RST     = 8'h00;
  localparam logic [7:0] SHIFT_DATA_RST      = 8'h00;

  // slave control a fields
  localparam int CA_DATA_IRQ_EN  = 7;
  localparam int CA_ADDR_STOP_EN = 6;
  localparam int CA_STOP_FLAG_EN = 5;
  localparam int CA_PROMISCUOUS  = 2;
  localparam int CA_SMART_MODE   = 1;
  localparam int CA_ENABLE       = 0;

  // slave control b fields
  localparam int CB_ACK_ACTION = 2;

  // slave status fields
  localparam int ST_DATA_FLAG   = 7;
  localparam int ST_ADDR_STOP   = 6;
  localparam int ST_CLOCK_HOLD  = 5;
  localparam int ST_RX_ACK      = 4;
  localparam int ST_COLLISION   = 3;
  localparam int ST_BUS_ERROR   = 2;
  localparam int ST_DIRECTION   = 1;
  localparam int ST_CAUSE       = 0;

  // command codes
  localparam logic [1:0] NO_ACTION_CODE            = 2'h0;
  localparam logic [1:0] RESERVED_CODE             = 2'h1;
  localparam logic [1:0] COMPLETE_TRANSACTION_CODE = 2'h2;
  localparam logic [1:0] RESPONSE_CODE             = 2'h3;

  // bits in a byte on the wire
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    TWS_IDLE, TWS_ADDR, TWS_HOLD, TWS_ACK, TWS_RX, TWS_TX, TWS_RACK,
    TWS_WAIT
  } tws_state_t;

  typedef enum logic [1:0] {TWS_NXT_RX, TWS_NXT_WAIT, TWS_NXT_DATA}
    tws_next_t;

endpackage : tws_pkg

// File: src/tws_slave.sv
// tws_slave: two-wire slave byte engine with control a, control b, status,
// own address and shift data registers behind a plain register port.
// assumes SCL and SDA pins sampled on CORE_CLK at least 4x the SCL rate,
// and a register master that keeps strobes one cycle long.
`timescale 1ns/1ps
module tws_slave
  import tws_pkg::*;
(
  // clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       RST,
  // register port
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  // processor global interrupt enable
  input  wire logic       GLOBAL_IRQ_EN,
  // interrupt requests
  output logic            DATA_IRQ,
  output logic            ADDR_STOP_IRQ,
  // two-wire pins
  input  wire logic       SCL_IN,
  output logic            SCL_OUT,
  output logic            SCL_OE,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE
);

  logic [7:0] ctrl_a_q;
  logic       ack_action_q;
  logic [7:0] own_addr_q;
  logic       data_flag_q;
  logic       addr_stop_flag_q;
  logic       collision_flag_q;
  logic       received_ack_q;
  logic       direction_q;
  logic       cause_q;
  logic       scl_s1_q, scl_s2_q, scl_s3_q;
  logic       sda_s1_q, sda_s2_q, sda_s3_q;
  tws_state_t st_q, st_d;
  tws_next_t  nxt_q, nxt_d;
  logic       kind_data_q, kind_data_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic       ackbit_q, ackbit_d;
  logic       addressed_q, addressed_d;
  logic       sda_oe_q, sda_oe_d;
  logic       scl_oe_q;
  logic [7:0] rdata_q;
  logic       data_irq_q, as_irq_q;

  logic       enable, smart, stop_flag_enable;
  logic       scl_rise, scl_fall, start_det, stop_det;
  logic       wr_a, wr_b, wr_st, wr_own, wr_data, rd_data;
  logic       holding, cmd_valid, data_acc, act, clr_ev, ack_val;
  logic [1:0] code;
  logic [7:0] tx_byte;
  logic       addr_match;
  logic       ev_addr, ev_stop, ev_data, ev_collision_flag, ev_nack_collision_flag, ev_received_ack;

  assign enable = ctrl_a_q[CA_ENABLE];
  assign smart  = ctrl_a_q[CA_SMART_MODE];
  assign stop_flag_enable   = ctrl_a_q[CA_STOP_FLAG_EN];

  // pin synchronisers; stage 3 is the previous value for edge finding
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end
    else
    begin
      scl_s1_q <= SCL_IN;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= SDA_IN;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  assign scl_rise  = scl_s2_q & ~scl_s3_q;
  assign scl_fall  = ~scl_s2_q & scl_s3_q;
  assign start_det = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  assign stop_det  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

  // register port decode
  assign wr_a    = REG_WR && REG_ADDR == SLAVE_CONTROL_A_OFS;
  assign wr_b    = REG_WR && REG_ADDR == SLAVE_CONTROL_B_OFS;
  assign wr_st   = REG_WR && REG_ADDR == SLAVE_STATUS_OFS;
  assign wr_own  = REG_WR && REG_ADDR == OWN_ADDRESS_OFS;
  assign wr_data = REG_WR && REG_ADDR == SHIFT_DATA_OFS;
  assign rd_data = REG_RD && REG_ADDR == SHIFT_DATA_OFS;

  assign holding   = st_q == TWS_HOLD;
  assign cmd_valid = wr_b && REG_WDATA[1];
  assign data_acc  = wr_data || rd_data;
  assign act       = holding && (cmd_valid || (smart && data_acc));
  assign clr_ev    = cmd_valid || (smart && data_acc);
  assign code      = cmd_valid ? REG_WDATA[1:0] : RESPONSE_CODE;
  assign ack_val   = wr_b ? REG_WDATA[CB_ACK_ACTION] : ack_action_q;
  assign tx_byte   = wr_data ? REG_WDATA : shift_q;
  assign addr_match = ctrl_a_q[CA_PROMISCUOUS]
    || shift_q[7:1] == own_addr_q[7:1]
    || (own_addr_q[0] && shift_q == 8'h00);

  // byte engine
  always_comb
  begin
    st_d         = st_q;
    nxt_d        = nxt_q;
    kind_data_d  = kind_data_q;
    cnt_d        = cnt_q;
    shift_d      = shift_q;
    ackbit_d     = ackbit_q;
    addressed_d  = addressed_q;
    sda_oe_d     = sda_oe_q;
    ev_addr      = 1'b0;
    ev_stop      = 1'b0;
    ev_data      = 1'b0;
    ev_collision_flag      = 1'b0;
    ev_nack_collision_flag = 1'b0;
    ev_received_ack     = 1'b0;
    if (holding && wr_data)
      shift_d = REG_WDATA;
    if (!enable)
    begin
      st_d        = TWS_IDLE;
      sda_oe_d    = 1'b0;
      addressed_d = 1'b0;
    end
    else if (start_det)
    begin
      st_d     = TWS_ADDR;
      cnt_d    = 4'h0;
      sda_oe_d = 1'b0;
    end
    else if (stop_det)
    begin
      ev_stop     = addressed_q && stop_flag_enable;
      addressed_d = 1'b0;
      st_d        = TWS_IDLE;
      sda_oe_d    = 1'b0;
    end
    else
    begin
      case (st_q)
        TWS_ADDR:
        begin
          if (scl_rise)
          begin
            shift_d = {shift_q[6:0], sda_s2_q};
            cnt_d   = cnt_q + 4'h1;
          end
          else if (scl_fall && cnt_q == BITS_PER_BYTE)
          begin
            if (addr_match)
            begin
              ev_addr     = 1'b1;
              addressed_d = 1'b1;
              kind_data_d = 1'b0;
              st_d        = TWS_HOLD;
            end
            else
              st_d = TWS_IDLE;
          end
        end
        TWS_HOLD:
        begin
          if (act && code == COMPLETE_TRANSACTION_CODE)
          begin
            if (!direction_q)
            begin
              st_d     = TWS_ACK;
              nxt_d    = TWS_NXT_WAIT;
              ackbit_d = ack_val;
              sda_oe_d = ~ack_val;
            end
            else
              st_d = TWS_WAIT;
          end
          else if (act && code == RESPONSE_CODE)
          begin
            if (direction_q && kind_data_q)
            begin
              st_d     = TWS_TX;
              cnt_d    = 4'h0;
              shift_d  = tx_byte;
              sda_oe_d = ~tx_byte[7];
            end
            else
            begin
              st_d     = TWS_ACK;
              nxt_d    = direction_q ? TWS_NXT_DATA : TWS_NXT_RX;
              ackbit_d = ack_val;
              sda_oe_d = ~ack_val;
            end
          end
          // release only once neither the data flag nor the address/stop flag is left pending
          else if (wr_st && (REG_WDATA[ST_DATA_FLAG] || !data_flag_q) &&
                   (REG_WDATA[ST_ADDR_STOP] || !addr_stop_flag_q))
            st_d = TWS_WAIT;
        end
        TWS_ACK:
        begin
          if (scl_rise && ackbit_q && !sda_s2_q)
          begin
            ev_collision_flag      = 1'b1;
            ev_nack_collision_flag = 1'b1;
          end
          else if (scl_fall)
          begin
            sda_oe_d = 1'b0;
            cnt_d    = 4'h0;
            case (nxt_q)
              TWS_NXT_RX:   st_d = TWS_RX;
              TWS_NXT_DATA:
              begin
                ev_data     = 1'b1;
                kind_data_d = 1'b1;
                st_d        = TWS_HOLD;
              end
              default:      st_d = TWS_WAIT;
            endcase
          end
        end
        TWS_RX:
        begin
          if (scl_rise)
          begin
            shift_d = {shift_q[6:0], sda_s2_q};
            cnt_d   = cnt_q + 4'h1;
          end
          else if (scl_fall && cnt_q == BITS_PER_BYTE)
          begin
            ev_data     = 1'b1;
            kind_data_d = 1'b1;
            st_d        = TWS_HOLD;
          end
        end
        TWS_TX:
        begin
          if (scl_rise)
          begin
            ev_collision_flag = shift_q[7] && !sda_s2_q;
            cnt_d   = cnt_q + 4'h1;
          end
          else if (scl_fall)
          begin
            shift_d = {shift_q[6:0], 1'b0};
            if (cnt_q == BITS_PER_BYTE)
            begin
              st_d     = TWS_RACK;
              sda_oe_d = 1'b0;
            end
            else
              sda_oe_d = ~shift_q[6];
          end
        end
        TWS_RACK:
        begin
          if (scl_rise)
            ev_received_ack = 1'b1;
          else if (scl_fall)
          begin
            ev_data     = 1'b1;
            kind_data_d = 1'b1;
            st_d        = TWS_HOLD;
          end
        end
        TWS_IDLE, TWS_WAIT: st_d = st_q;
        default:            st_d = TWS_IDLE;
      endcase
    end
    if (collision_flag_q || ev_collision_flag)
      sda_oe_d = 1'b0;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      st_q        <= TWS_IDLE;
      nxt_q       <= TWS_NXT_WAIT;
      kind_data_q <= 1'b0;
      cnt_q       <= 4'h0;
      shift_q     <= SHIFT_DATA_RST;
      ackbit_q    <= 1'b0;
      addressed_q <= 1'b0;
      sda_oe_q    <= 1'b0;
      scl_oe_q    <= 1'b0;
    end
    else
    begin
      st_q        <= st_d;
      nxt_q       <= nxt_d;
      kind_data_q <= kind_data_d;
      cnt_q       <= cnt_d;
      shift_q     <= shift_d;
      ackbit_q    <= ackbit_d;
      addressed_q <= addressed_d;
      sda_oe_q    <= sda_oe_d;
      scl_oe_q    <= st_d == TWS_HOLD;
    end
  end

  // control registers
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      ctrl_a_q     <= SLAVE_CONTROL_A_RST;
      ack_action_q <= 1'b0;
      own_addr_q   <= OWN_ADDRESS_RST;
    end
    else
    begin
      if (wr_a)
        ctrl_a_q <= REG_WDATA & 8'he7;
      if (wr_b)
        ack_action_q <= REG_WDATA[CB_ACK_ACTION];
      if (wr_own)
        own_addr_q <= REG_WDATA;
    end
  end

  // status flags; a hardware set wins over any clear in the same cycle
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      data_flag_q      <= 1'b0;
      addr_stop_flag_q <= 1'b0;
      collision_flag_q <= 1'b0;
      received_ack_q   <= 1'b0;
      direction_q      <= 1'b0;
      cause_q          <= 1'b0;
    end
    else
    begin
      if (ev_data)
        data_flag_q <= 1'b1;
      else if (clr_ev || (wr_st && REG_WDATA[ST_DATA_FLAG]))
        data_flag_q <= 1'b0;
      if (ev_addr || ev_stop || ev_nack_collision_flag)
        addr_stop_flag_q <= 1'b1;
      else if (clr_ev || (wr_st && REG_WDATA[ST_ADDR_STOP]))
        addr_stop_flag_q <= 1'b0;
      if (ev_collision_flag)
        collision_flag_q <= 1'b1;
      else if ((enable && start_det) ||
               (wr_st && REG_WDATA[ST_COLLISION]))
        collision_flag_q <= 1'b0;
      if (ev_received_ack)
        received_ack_q <= sda_s2_q;
      if (ev_addr)
      begin
        direction_q <= shift_q[0];
        cause_q     <= 1'b1;
      end
      else if (ev_stop)
        cause_q <= 1'b0;
    end
  end

  // interrupt requests and read data
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      data_irq_q <= 1'b0;
      as_irq_q   <= 1'b0;
      rdata_q    <= 8'h00;
    end
    else
    begin
      data_irq_q <= ctrl_a_q[CA_DATA_IRQ_EN] && data_flag_q &&
                    GLOBAL_IRQ_EN;
      as_irq_q   <= ctrl_a_q[CA_ADDR_STOP_EN] && addr_stop_flag_q &&
                    stop_flag_enable && GLOBAL_IRQ_EN;
      if (REG_RD)
      begin
        case (REG_ADDR)
          SLAVE_CONTROL_A_OFS: rdata_q <= ctrl_a_q;
          SLAVE_CONTROL_B_OFS: rdata_q <= {5'h00, ack_action_q, 2'h0};
          SLAVE_STATUS_OFS:    rdata_q <= {data_flag_q, addr_stop_flag_q,
            holding, received_ack_q, collision_flag_q, 1'b0,
            direction_q, cause_q};
          OWN_ADDRESS_OFS:     rdata_q <= own_addr_q;
          SHIFT_DATA_OFS:      rdata_q <= shift_q;
          default:             rdata_q <= 8'h00;
        endcase
      end
      else
        rdata_q <= 8'h00;
    end
  end

  assign REG_RDATA     = rdata_q;
  assign DATA_IRQ      = data_irq_q;
  assign ADDR_STOP_IRQ = as_irq_q;
  assign SCL_OUT       = 1'b0;
  assign SCL_OE        = scl_oe_q;
  assign SDA_OUT       = 1'b0;
  assign SDA_OE        = sda_oe_q;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  sequence s_smart_access;
    holding && smart && data_acc && !wr_b;
  endsequence

  a_data_irq_gate: assert property (
    ctrl_a_q[CA_DATA_IRQ_EN] && data_flag_q && GLOBAL_IRQ_EN |=> DATA_IRQ)
    else $error("data interrupt not raised");
  a_stop_irq_gate: assert property (
    !stop_flag_enable ##1 !stop_flag_enable |-> !ADDR_STOP_IRQ)
    else $error("address/stop interrupt without stop enable");
  a_stop_sets_flag: assert property (
    ev_stop |=> addr_stop_flag_q && !cause_q)
    else $error("stop did not set flag with cause zero");
  a_disabled_quiet: assert property (
    !enable ##1 !enable |-> !SDA_OE && !SCL_OE)
    else $error("disabled slave drives the bus");
  a_cmd_reads_zero: assert property (
    REG_RD && REG_ADDR == SLAVE_CONTROL_B_OFS |=> REG_RDATA[1:0] == 2'h0)
    else $error("command field did not read zero");
  a_hold_has_flag: assert property (
    SCL_OE |-> data_flag_q || addr_stop_flag_q)
    else $error("clock held with no pending flag");
  a_collision_flag_no_low: assert property (
    collision_flag_q |-> !SDA_OE)
    else $error("SDA driven low during collision");
  a_start_clears_collision_flag: assert property (
    enable && start_det |=> !collision_flag_q)
    else $error("start did not clear collision");
  a_smart_continue: assert property (
    s_smart_access |=> !SCL_OE && !data_flag_q && !addr_stop_flag_q)
    else $error("smart data access did not release hold");
  a_no_smart_stall: assert property (
    holding && !smart && data_acc |=> SCL_OE && holding)
    else $error("slave continued without a command");

endmodule : tws_slave

// File: dv/tws_master.sv
// tws_master: behavioural two-wire bus master driving open-drain lines.
// assumes the bench resolves scl_line and sda_line with pull-ups.
`timescale 1ns/1ps
module tws_master (
  // resolved line levels
  input  wire logic scl_line,
  input  wire logic sda_line,
  // pull-down requests of this master
  output logic      scl_low,
  output logic      sda_low
);
  localparam int QTR = 80;
  int stretch_timeouts;

  initial
  begin
    scl_low          = 1'b0;
    sda_low          = 1'b0;
    stretch_timeouts = 0;
  end

  // release scl and wait while the slave stretches the low phase
  task automatic rise_scl;
    int n;
    n = 0;
    scl_low = 1'b0;
    while (scl_line !== 1'b1 && n < 5000)
    begin
      #10;
      n++;
    end
    if (n >= 5000)
      stretch_timeouts++;
  endtask : rise_scl

  task automatic clock_bit(input logic b, output logic r);
    sda_low = ~b;
    #QTR;
    rise_scl;
    #QTR;
    r = sda_line;
    #QTR;
    scl_low = 1'b1;
    #QTR;
  endtask : clock_bit

  // msb first; pass all ones to read what the slave sends
  task automatic xfer8(input logic [7:0] d, output logic [7:0] r);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      clock_bit(d[i], b);
      r[i] = b;
    end
  endtask : xfer8

  // start or repeated start
  task automatic start;
    sda_low = 1'b0;
    #QTR;
    rise_scl;
    #(2 * QTR);
    sda_low = 1'b1;
    #(2 * QTR);
    scl_low = 1'b1;
    #QTR;
  endtask : start

  task automatic stop;
    sda_low = 1'b1;
    #QTR;
    rise_scl;
    #(2 * QTR);
    sda_low = 1'b0;
    #(2 * QTR);
  endtask : stop
endmodule : tws_master

// File: dv/testbench.sv
// testbench: register-level tests of the two-wire slave with a bus master.
// assumes tws_pkg, tws_slave and tws_master are compiled before it.
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("mismatch %s expected %h seen %h", what, exp, got); \
    end \
  end
module testbench
  import tws_pkg::*;
;
  logic       core_clk;
  logic       rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       global_irq_en;
  logic       data_irq;
  logic       addr_stop_irq;
  logic       scl_out;
  logic       scl_oe;
  logic       sda_out;
  logic       sda_oe;
  logic       m_scl_low;
  logic       m_sda_low;
  wire logic  scl_line;
  wire logic  sda_line;
  int         n_fail;
  int         samples_checked;
  logic [7:0] r8;
  logic       rb;

  // open-drain lines with pull-ups
  assign scl_line = !(m_scl_low || (scl_oe && !scl_out));
  assign sda_line = !(m_sda_low || (sda_oe && !sda_out));

  tws_slave DUT (
    .CORE_CLK      (core_clk),
    .RST           (rst),
    .REG_ADDR      (reg_addr),
    .REG_WDATA     (reg_wdata),
    .REG_WR        (reg_wr),
    .REG_RD        (reg_rd),
    .REG_RDATA     (reg_rdata),
    .GLOBAL_IRQ_EN (global_irq_en),
    .DATA_IRQ      (data_irq),
    .ADDR_STOP_IRQ (addr_stop_irq),
    .SCL_IN        (scl_line),
    .SCL_OUT       (scl_out),
    .SCL_OE        (scl_oe),
    .SDA_IN        (sda_line),
    .SDA_OUT       (sda_out),
    .SDA_OE        (sda_oe)
  );

  tws_master m (
    .scl_line (scl_line),
    .sda_line (sda_line),
    .scl_low  (m_scl_low),
    .sda_low  (m_sda_low)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd_reg

  task automatic chk_reg(input string what, input logic [7:0] a,
                         input logic [7:0] mask, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(a, d);
    `CHK(what, exp, d & mask)
  endtask : chk_reg

  task automatic wait_hold;
    int n;
    n = 0;
    while (scl_oe !== 1'b1 && n < 40)
    begin
      @(posedge core_clk);
      n++;
    end
    `CHK("clock hold pin", 1'b1, scl_oe)
  endtask : wait_hold

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  initial
  begin
    #2000000;
    n_fail++;
    end_sim;
  end

  initial
  begin
    rst             = 1'b1;
    reg_addr        = 8'h00;
    reg_wdata       = 8'h00;
    reg_wr          = 1'b0;
    reg_rd          = 1'b0;
    global_irq_en   = 1'b0;
    n_fail          = 0;
    samples_checked = 0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    // register reset values, access kinds, unmapped place
    for (int i = 9; i <= 13; i++)
      chk_reg("reset value", 8'(i), 8'hff, 8'h00);
    chk_reg("unmapped", 8'h20, 8'hff, 8'h00);
    wr_reg(SLAVE_CONTROL_A_OFS, 8'hff);
    chk_reg("control a", SLAVE_CONTROL_A_OFS, 8'hff, 8'he7);
    wr_reg(SLAVE_CONTROL_B_OFS, 8'h07);
    chk_reg("control b", SLAVE_CONTROL_B_OFS, 8'hff, 8'h04);
    wr_reg(SLAVE_CONTROL_B_OFS, 8'h01);
    chk_reg("reserved cmd", SLAVE_CONTROL_B_OFS, 8'hff, 8'h00);
    wr_reg(SLAVE_STATUS_OFS, 8'hff);
    chk_reg("status ro", SLAVE_STATUS_OFS, 8'hff, 8'h00);
    wr_reg(SLAVE_CONTROL_A_OFS, 8'h00);
    wr_reg(OWN_ADDRESS_OFS, 8'h84);
    // disabled slave ignores its own address
    m.start;
    m.xfer8(8'h84, r8);
    m.clock_bit(1'b1, rb);
    `CHK("ack while disabled", 1'b1, rb)
    m.stop;
    chk_reg("status disabled", SLAVE_STATUS_OFS, 8'hff, 8'h00);
    // foreign address and stop while not addressed
    wr_reg(SLAVE_CONTROL_A_OFS, 8'he1);
    global_irq_en <= 1'b1;
    m.start;
    m.xfer8(8'h90, r8);
    m.clock_bit(1'b1, rb);
    `CHK("foreign address ack", 1'b1, rb)
    m.stop;
    chk_reg("status foreign", SLAVE_STATUS_OFS, 8'hff, 8'h00);
    // master write: address, one byte, nack by complete transaction
    m.start;
    m.xfer8(8'h84, r8);
    wait_hold;
    chk_reg("addr match", SLAVE_STATUS_OFS, 8'he3, 8'h61);
    `CHK("addr irq", 1'b1, addr_stop_irq)
    global_irq_en <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK("addr irq masked", 1'b0, addr_stop_irq)
    global_irq_en <= 1'b1;
    wr_reg(SLAVE_CONTROL_B_OFS, 8'h03);
    chk_reg("after cmd", SLAVE_STATUS_OFS, 8'he0, 8'h00);
    m.clock_bit(1'b1, rb);
    `CHK("address ack", 1'b0, rb)
    m.xfer8(8'h3c, r8);
    wait_hold;
    chk_reg("byte received", SLAVE_STATUS_OFS, 8'he0, 8'ha0);
    `CHK("data irq", 1'b1, data_irq)
    chk_reg("rx data", SHIFT_DATA_OFS, 8'hff, 8'h3c);
    chk_reg("no smart stall", SLAVE_STATUS_OFS, 8'he0, 8'ha0);
    wr_reg(SLAVE_CONTROL_B_OFS, 8'h06);
    m.clock_bit(1'b1, rb);
    `CHK("nack by cmd2", 1'b1, rb)
    m.stop;
    chk_reg("stop flag", SLAVE_STATUS_OFS, 8'h41, 8'h40);
    `CHK("stop irq", 1'b1, addr_stop_irq)
    wr_reg(SLAVE_STATUS_OFS, 8'h40);
    chk_reg("flag w1c", SLAVE_STATUS_OFS, 8'h40, 8'h00);
    // master read: two bytes, the second one collides
    wr_reg(SLAVE_CONTROL_B_OFS, 8'h00);
    m.start;
    m.xfer8(8'h85, r8);
    wait_hold;
    chk_reg("read dir", SLAVE_STATUS_OFS, 8'h43, 8'h43);
    wr_reg(SLAVE_CONTROL_B_OFS, 8'h03);
    m.clock_bit(1'b1, rb);
    `CHK("read address ack", 1'b0, rb)
    wait_hold;
    chk_reg("tx data irq", SLAVE_STATUS_OFS, 8'he0, 8'ha0);
    wr_reg(SHIFT_DATA_OFS, 8'h5a);
    wr_reg(SLAVE_CONTROL_B_OFS, 8'h03);
    m.xfer8(8'hff, r8);
    `CHK("tx byte", 8'h5a, r8)
    m.clock_bit(1'b0, rb);
    wait_hold;
    chk_reg("master ack", SLAVE_STATUS_OFS, 8'h98, 8'h80);
    wr_reg(SHIFT_DATA_OFS, 8'ha5);
    wr_reg(SLAVE_CONTROL_B_OFS, 8'h03);
    m.xfer8(8'h7f, r8);
    `CHK("lows suppressed", 8'h7f, r8)
    m.clock_bit(1'b1, rb);
    wait_hold;
    chk_reg("collision", SLAVE_STATUS_OFS, 8'h98, 8'h98);
    wr_reg(SLAVE_CONTROL_B_OFS, 8'h02);
    m.start;
    chk_reg("collision_flag by start", SLAVE_STATUS_OFS, 8'h08, 8'h00);
    m.stop;
    wr_reg(SLAVE_STATUS_OFS, 8'hc8);
    // smart mode with promiscuous match
    wr_reg(SLAVE_CONTROL_A_OFS, 8'h07);
    m.start;
    m.xfer8(8'h20, r8);
    wait_hold;
    chk_reg("promiscuous", SLAVE_STATUS_OFS, 8'h41, 8'h41);
    chk_reg("smart read", SHIFT_DATA_OFS, 8'hff, 8'h20);
    chk_reg("smart release", SLAVE_STATUS_OFS, 8'h60, 8'h00);
    m.clock_bit(1'b1, rb);
    `CHK("smart ack", 1'b0, rb)
    m.xfer8(8'h99, r8);
    wait_hold;
    `CHK("data irq disabled", 1'b0, data_irq)
    chk_reg("smart rx", SHIFT_DATA_OFS, 8'hff, 8'h99);
    m.clock_bit(1'b1, rb);
    `CHK("smart data ack", 1'b0, rb)
    m.stop;
    chk_reg("stop disabled", SLAVE_STATUS_OFS, 8'h40, 8'h00);
    `CHK("stretch timeouts", 0, m.stretch_timeouts)
    end_sim;
  end
endmodule : testbench
